// ===== shared/index_stack_map.vh
// Constants for the index extension decoder and stack pointer unit.
`ifndef INDEX_STACK_MAP_VH
`define INDEX_STACK_MAP_VH
`define EXT_CLASS_BIT 15
`define EXT_REG_HI 14
`define EXT_REG_LO 12
`define EXT_SIZE_BIT 11
`define EXT_SCALE_HI 10
`define EXT_SCALE_LO 9
`define EXT_DISP_HI 7
`define EXT_DISP_LO 0
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define MODE_NONE 3'h0
`define MODE_POSTINC 3'h1
`define MODE_PREDEC 3'h2
`define MODE_CALL 3'h3
`define MODE_RETURN 3'h4
`define MODE_TRAP 3'h5
`define STACK_REG_NUM 3'h7
`define STEP_BYTE 3'h1
`define STEP_WORD 3'h2
`define STEP_LONG 3'h4
`define STEP_FRAME 3'h6
`define PTR_RESET 32'h00000000
`endif

// ===== core/index_ext_decode_and_stack_ptr.v
// Brief index extension decoder and system stack pointer unit.
// Operation
// [RQ1] Bit 15 selects data or address index.
// [RQ2] Bit 11 selects word or long index.
// [RQ3] Scale codes give factor 1, 2, 4, 8.
// [RQ4] Scale shifts index; register stays unchanged.
// [RQ5] Word index sign-extends low 16 bits.
// [RQ6] Bits 14-12 register, bits 7-0 displacement.
// [RQ7] Register seven maps to the active pointer.
// [RQ8] Supervisor state uses supervisor stack pointer.
// [RQ9] User state uses user stack pointer.
// [RQ10] Stacks grow down; predecrement pushes, postincrement pops.
// [RQ11] Calls push PC; returns pop active stack.
// [RQ12] Traps save PC and status on supervisor.
// [RQ13] Stack pointer always moves by whole words.
// [RQ14] Stack bytes sit in high half.
// [RQ15] Predecrement updates first, then addresses.
// [RQ16] Postincrement addresses first, then updates.
// [RQ17] Step equals size; byte via seven steps two.
`timescale 1ns/100ps
`default_nettype none
`include "index_stack_map.vh"
module index_ext_decode_and_stack_ptr #(
    parameter WIDTH = 32
) (
    // Clock and reset.
    input wire ref_clk_in,
    input wire sys_rst_in,
    // Extension word decode request.
    input wire ext_valid_in,
    input wire [15:0] ext_word_in,
    input wire [WIDTH-1:0] base_addr_in,
    input wire [WIDTH*16-1:0] gen_regs_in,
    // Stack access request.
    input wire stk_valid_in,
    input wire [2:0] stk_mode_in,
    input wire [2:0] stk_reg_in,
    input wire [1:0] stk_size_in,
    input wire [WIDTH-1:0] addr_reg_in,
    input wire supervisor_in,
    // Direct pointer loads.
    input wire user_ptr_load_in,
    input wire super_ptr_load_in,
    input wire [WIDTH-1:0] ptr_data_in,
    // Decode results.
    output reg ext_done_out,
    output reg idx_is_addr_out,
    output reg [2:0] idx_reg_out,
    output reg idx_long_out,
    output reg [1:0] idx_shift_out,
    output reg [WIDTH-1:0] eff_addr_out,
    // Stack results.
    output reg stk_done_out,
    output reg [WIDTH-1:0] mem_addr_out,
    output reg [WIDTH-1:0] new_reg_out,
    output reg save_status_out,
    output reg byte_high_out,
    output reg [WIDTH-1:0] active_stack_ptr_out,
    output reg [WIDTH-1:0] user_stack_ptr_out,
    output reg [WIDTH-1:0] supervisor_stack_ptr_out
);

    // Pointer state; only the stack path and the direct loads write it.
    reg [WIDTH-1:0] user_stack_ptr_q;
    reg [WIDTH-1:0] supervisor_stack_ptr_q;
    // Datapath intermediates, all combinational.
    reg [WIDTH-1:0] index_raw;
    reg [WIDTH-1:0] index_ext;
    reg [WIDTH-1:0] index_scaled;
    reg [WIDTH-1:0] disp_ext;
    reg [WIDTH-1:0] eff_addr_d;
    reg [WIDTH-1:0] step;
    reg [WIDTH-1:0] cur_ptr;
    reg [WIDTH-1:0] updated;
    reg [WIDTH-1:0] mem_addr_d;
    reg use_super;
    reg via_seven;
    reg push_op;
    wire [3:0] idx_sel;
    wire [WIDTH-1:0] active_stack_ptr;
    wire stk_take;

    // Register number with class on top: 0-7 data, 8-15 address.
    assign idx_sel = {ext_word_in[`EXT_CLASS_BIT], ext_word_in[`EXT_REG_HI:`EXT_REG_LO]}; // RQ1 RQ6
    // The active pointer follows the supervisor bit.
    assign active_stack_ptr = supervisor_in ? supervisor_stack_ptr_q : user_stack_ptr_q; // RQ8 RQ9

    // A request with mode none is dropped, so only real accesses are taken.
    assign stk_take = stk_valid_in && (stk_mode_in != `MODE_NONE);

    // Modes that always go through the system stack, whatever register is named.
    function implied_stack;
        input [2:0] mode;
        begin
            implied_stack = (mode == `MODE_CALL) || (mode == `MODE_RETURN)
                || (mode == `MODE_TRAP);
        end
    endfunction

    // Index selection, sizing, scaling and displacement addition.
    // The three-input add sits in front of one register; an extra stage would
    // ease timing but cost the one-cycle answer the fetch path relies on.
    always @*
    begin
        if (idx_sel == {1'b1, `STACK_REG_NUM})
            index_raw = active_stack_ptr; // RQ7
        else
            index_raw = gen_regs_in[idx_sel*WIDTH +: WIDTH];
        if (ext_word_in[`EXT_SIZE_BIT])
            index_ext = index_raw; // RQ2 RQ5
        else
            index_ext = {{(WIDTH-16){index_raw[15]}}, index_raw[15:0]}; // RQ5
        // Shift a copy only; the register file is never written here.
        index_scaled = index_ext << ext_word_in[`EXT_SCALE_HI:`EXT_SCALE_LO]; // RQ3 RQ4
        disp_ext = {{(WIDTH-8){ext_word_in[`EXT_DISP_HI]}},
            ext_word_in[`EXT_DISP_HI:`EXT_DISP_LO]}; // RQ6
        eff_addr_d = base_addr_in + index_scaled + disp_ext;
    end

    // Stack access address and pointer update.
    always @*
    begin
        via_seven = (stk_reg_in == `STACK_REG_NUM) || implied_stack(stk_mode_in); // RQ7
        push_op = (stk_mode_in == `MODE_PREDEC) || (stk_mode_in == `MODE_CALL)
            || (stk_mode_in == `MODE_TRAP); // RQ10 RQ11
        // Traps always land on the supervisor stack whatever the state.
        use_super = supervisor_in || (stk_mode_in == `MODE_TRAP); // RQ12
        // A byte through seven rounds up to a word to keep the pointer aligned.
        // Frames for calls, returns and traps move the pointer by fixed amounts.
        if (stk_mode_in == `MODE_CALL || stk_mode_in == `MODE_RETURN)
            step = {{(WIDTH-3){1'b0}}, `STEP_LONG}; // RQ11
        else if (stk_mode_in == `MODE_TRAP)
            step = {{(WIDTH-3){1'b0}}, `STEP_FRAME}; // Status word plus program counter.
        else if (stk_size_in == `SZ_LONG)
            step = {{(WIDTH-3){1'b0}}, `STEP_LONG}; // RQ17
        else if (stk_size_in == `SZ_WORD || via_seven)
            step = {{(WIDTH-3){1'b0}}, `STEP_WORD}; // RQ13 RQ17
        else
            step = {{(WIDTH-3){1'b0}}, `STEP_BYTE}; // RQ17
        // Register seven and the implied modes read the selected stack pointer.
        if (!via_seven)
            cur_ptr = addr_reg_in;
        else if (use_super)
            cur_ptr = supervisor_stack_ptr_q; // RQ7
        else
            cur_ptr = user_stack_ptr_q;
        // A push addresses the lowered pointer; a pop addresses the old one.
        if (push_op)
        begin
            updated = cur_ptr - step;
            mem_addr_d = updated; // RQ15
        end
        else
        begin
            updated = cur_ptr + step;
            mem_addr_d = cur_ptr; // RQ16
        end
    end

    // Pointer registers and registered outputs.
    always @(posedge ref_clk_in)
    begin
        // Reset clears every pointer and every result.
        if (sys_rst_in)
        begin
            user_stack_ptr_q <= `PTR_RESET;
            supervisor_stack_ptr_q <= `PTR_RESET;
            ext_done_out <= 1'b0;
            idx_is_addr_out <= 1'b0;
            idx_reg_out <= 3'h0;
            idx_long_out <= 1'b0;
            idx_shift_out <= 2'h0;
            eff_addr_out <= `PTR_RESET;
            stk_done_out <= 1'b0;
            mem_addr_out <= `PTR_RESET;
            new_reg_out <= `PTR_RESET;
            save_status_out <= 1'b0;
            byte_high_out <= 1'b0;
            active_stack_ptr_out <= `PTR_RESET;
            user_stack_ptr_out <= `PTR_RESET;
            supervisor_stack_ptr_out <= `PTR_RESET;
        end
        else
        begin
            // Decode fields hold until the next decode request.
            ext_done_out <= ext_valid_in;
            if (ext_valid_in)
            begin
                idx_is_addr_out <= ext_word_in[`EXT_CLASS_BIT]; // RQ1
                idx_reg_out <= ext_word_in[`EXT_REG_HI:`EXT_REG_LO]; // RQ6
                idx_long_out <= ext_word_in[`EXT_SIZE_BIT]; // RQ2
                idx_shift_out <= ext_word_in[`EXT_SCALE_HI:`EXT_SCALE_LO]; // RQ3
                eff_addr_out <= eff_addr_d;
            end
            // Stack results hold until the next taken request.
            stk_done_out <= stk_take;
            if (stk_take)
            begin
                mem_addr_out <= mem_addr_d;
                new_reg_out <= updated;
                save_status_out <= (stk_mode_in == `MODE_TRAP); // RQ12
                // A byte through the stack pointer uses the upper lane only.
                byte_high_out <= via_seven && (stk_size_in == `SZ_BYTE)
                    && (stk_mode_in == `MODE_PREDEC || stk_mode_in == `MODE_POSTINC); // RQ14
            end
            // Stack updates win over a same-cycle direct load.
            if (stk_take && via_seven && use_super)
                supervisor_stack_ptr_q <= updated; // RQ10
            else if (super_ptr_load_in)
                supervisor_stack_ptr_q <= ptr_data_in;
            if (stk_take && via_seven && !use_super)
                user_stack_ptr_q <= updated; // RQ10
            else if (user_ptr_load_in)
                user_stack_ptr_q <= ptr_data_in;
            // Mirror copies run one cycle behind the pointer registers.
            active_stack_ptr_out <= active_stack_ptr;
            user_stack_ptr_out <= user_stack_ptr_q;
            supervisor_stack_ptr_out <= supervisor_stack_ptr_q;
        end
    end

endmodule
`default_nettype wire

// ===== bench/idx_stk_props.sv
// Port-level assertions for the index decoder and stack pointer unit.
`timescale 1ns/100ps
`default_nettype none
module idx_stk_props #(parameter WIDTH = 32) (
    // Clock, reset and requests.
    input wire logic ref_clk_in, sys_rst_in, ext_valid_in, stk_valid_in,
    input wire logic [15:0] ext_word_in,
    input wire logic [2:0] stk_mode_in, stk_reg_in,
    input wire logic [1:0] stk_size_in,
    // Results.
    input wire logic ext_done_out, idx_is_addr_out, idx_long_out, stk_done_out,
    input wire logic save_status_out, byte_high_out,
    input wire logic [1:0] idx_shift_out,
    input wire logic [WIDTH-1:0] mem_addr_out, new_reg_out
);
    // One clock domain, so all checks are muted only by its reset.
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic stk_req = stk_valid_in && stk_mode_in != 3'h0;
    wire logic pop7 = stk_valid_in && stk_mode_in == 3'h1 && stk_reg_in == 3'h7;
    a_decode_done: assert property (ext_valid_in |=> ext_done_out)
        else $error("decode done missing");
    a_done_pulse: assert property (!ext_valid_in |=> !ext_done_out)
        else $error("decode done stuck");
    a_class_bit: assert property (
        ext_valid_in |=> idx_is_addr_out == $past(ext_word_in[15]))
        else $error("index class wrong");
    a_size_bit: assert property (
        ext_valid_in |=> idx_long_out == $past(ext_word_in[11]))
        else $error("index size wrong");
    a_scale_field: assert property (
        ext_valid_in |=> idx_shift_out == $past(ext_word_in[10:9]))
        else $error("scale shift wrong");
    a_stack_done: assert property (stk_req |=> stk_done_out)
        else $error("stack done missing");
    a_stack_idle: assert property (!stk_req |=> !stk_done_out)
        else $error("stack done stuck");
    a_trap_status: assert property (
        stk_req |=> save_status_out == ($past(stk_mode_in) == 3'h5))
        else $error("status save wrong");
    a_predec_addr: assert property (
        stk_valid_in && stk_mode_in == 3'h2 |=> mem_addr_out == new_reg_out)
        else $error("predecrement address wrong");
    a_byte_high: assert property (
        (pop7 || stk_valid_in && stk_mode_in == 3'h2 && stk_reg_in == 3'h7)
        && stk_size_in == 2'h0 |=> byte_high_out)
        else $error("byte lane wrong");
    a_pop_step: assert property (
        pop7 |=> new_reg_out - mem_addr_out == ($past(stk_size_in) == 2'h2 ? 4 : 2))
        else $error("pop step wrong");
endmodule
bind index_ext_decode_and_stack_ptr idx_stk_props #(.WIDTH(WIDTH)) u_idx_stk_props (
    .ref_clk_in, .sys_rst_in, .ext_valid_in, .stk_valid_in, .ext_word_in,
    .stk_mode_in, .stk_reg_in, .stk_size_in, .ext_done_out, .idx_is_addr_out,
    .idx_long_out, .stk_done_out, .save_status_out, .byte_high_out,
    .idx_shift_out, .mem_addr_out, .new_reg_out);
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the index decoder and stack pointer unit.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    reg ref_clk_in = 1'b0, sys_rst_in = 1'b1, ext_valid_in = 1'b0, stk_valid_in = 1'b0;
    reg supervisor_in = 1'b0, user_ptr_load_in = 1'b0, super_ptr_load_in = 1'b0;
    reg [15:0] ext_word_in = 16'h0000;
    reg [2:0] stk_mode_in = 3'h0, stk_reg_in = 3'h0;
    reg [1:0] stk_size_in = 2'h0;
    reg [31:0] base_addr_in = 32'h0, addr_reg_in = 32'h0, ptr_data_in = 32'h0;
    reg [31:0] usr_ptr, sup_ptr, p, e, n;
    reg [511:0] gen_regs_in = 512'h0;
    wire ext_done_out, idx_is_addr_out, idx_long_out, stk_done_out, save_status_out, byte_high_out;
    wire [2:0] idx_reg_out;
    wire [1:0] idx_shift_out;
    wire [31:0] eff_addr_out, mem_addr_out, new_reg_out, active_stack_ptr_out, user_stack_ptr_out;
    wire [31:0] supervisor_stack_ptr_out;
    integer seed = 32'hFC881BC7, err_count = 0, cmp_count = 0, cyc = 0, i, k, st;
    index_ext_decode_and_stack_ptr u_index_ext_decode_and_stack_ptr (.ref_clk_in, .sys_rst_in,
        .ext_valid_in, .ext_word_in, .base_addr_in, .gen_regs_in, .stk_valid_in, .stk_mode_in,
        .stk_reg_in, .stk_size_in, .addr_reg_in, .supervisor_in, .user_ptr_load_in,
        .super_ptr_load_in, .ptr_data_in, .ext_done_out, .idx_is_addr_out, .idx_reg_out,
        .idx_long_out, .idx_shift_out, .eff_addr_out, .stk_done_out, .mem_addr_out,
        .new_reg_out, .save_status_out, .byte_high_out,
        .active_stack_ptr_out, .user_stack_ptr_out, .supervisor_stack_ptr_out);
    always #12.5 ref_clk_in = ~ref_clk_in;
    // Compares one value and counts the outcome.
    task chk(input [8*8-1:0] nm, input [31:0] got, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Slot 15 stands for the active stack pointer, which the bench tracks itself.
    function [31:0] ea(input [15:0] w);
        reg [31:0] x;
        begin
            if (w[15:12] == 4'hF)
                x = supervisor_in ? sup_ptr : usr_ptr;
            else
                x = gen_regs_in[w[15:12]*32 +: 32];
            if (!w[11])
                x = {{16{x[15]}}, x[15:0]};
            ea = base_addr_in + (x << w[10:9]) + {{24{w[7]}}, w[7:0]};
        end
    endfunction
    task dec(input [15:0] w);
        @(posedge ref_clk_in);
        #1;
        chk("eidle", ext_done_out, 32'h0);
        for (k = 0; k < 16; k = k + 1)
            gen_regs_in[k*32 +: 32] = $random(seed);
        base_addr_in = $random(seed);
        supervisor_in = $random(seed);
        ext_word_in = w;
        ext_valid_in = 1'b1;
        @(posedge ref_clk_in);
        #1 ext_valid_in = 1'b0;
        chk("edone", ext_done_out, 32'h1);
        chk("eclass", idx_is_addr_out, w[15]);
        chk("elong", idx_long_out, w[11]);
        chk("eshift", idx_shift_out, w[10:9]);
        chk("ereg", idx_reg_out, w[14:12]);
        chk("eaddr", eff_addr_out, ea(w));
    endtask
    // The bench tracks both stack pointers to predict each access.
    task stk(input [2:0] m, input [2:0] r, input [1:0] s, input sv);
        @(posedge ref_clk_in);
        #1;
        chk("sidle", stk_done_out, 32'h0);
        stk_mode_in = m;
        stk_reg_in = r;
        stk_size_in = s;
        supervisor_in = sv;
        addr_reg_in = $random(seed);
        stk_valid_in = 1'b1;
        p = (m == 3'h5 || sv) ? sup_ptr : usr_ptr;
        if (r != 3'h7 && m < 3'h3)
            p = addr_reg_in;
        st = m == 3'h5 ? 6 : (m > 3'h2 || s == 2'h2) ? 4 : (s == 2'h1 || r == 3'h7) ? 2 : 1;
        n = (m == 3'h1 || m == 3'h4) ? p + st : p - st;
        e = (m == 3'h1 || m == 3'h4) ? p : n;
        if (r == 3'h7 || m > 3'h2)
        begin
            if (m == 3'h5 || sv)
                sup_ptr = n;
            else
                usr_ptr = n;
        end
        @(posedge ref_clk_in);
        #1 stk_valid_in = 1'b0;
        chk("sdone", stk_done_out, 32'h1);
        chk("maddr", mem_addr_out, e);
        chk("nreg", new_reg_out, n);
        chk("status", save_status_out, m == 3'h5);
        chk("bhigh", byte_high_out, r == 3'h7 && m < 3'h3 && s == 2'h0);
        @(posedge ref_clk_in);
        #1;
        chk("uptr", user_stack_ptr_out, usr_ptr);
        chk("sptr", supervisor_stack_ptr_out, sup_ptr);
        chk("act", active_stack_ptr_out, sv ? sup_ptr : usr_ptr);
    endtask
    // Cuts a hung run short.
    always @(posedge ref_clk_in)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            close_out;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        #1 sys_rst_in = 1'b0;
        chk("rst", active_stack_ptr_out, 32'h0);
        usr_ptr = 32'h00001000;
        sup_ptr = 32'h00002000;
        ptr_data_in = usr_ptr;
        user_ptr_load_in = 1'b1;
        @(posedge ref_clk_in);
        #1 user_ptr_load_in = 1'b0;
        ptr_data_in = sup_ptr;
        super_ptr_load_in = 1'b1;
        @(posedge ref_clk_in);
        #1 super_ptr_load_in = 1'b0;
        for (i = 0; i < 4; i = i + 1) dec({$random(seed)} & 16'hF9FF | i << 9);
        for (i = 0; i < 20; i = i + 1) dec($random(seed));
        stk(3'h2, 3'h7, 2'h0, 1'b0);
        stk(3'h1, 3'h7, 2'h0, 1'b0);
        stk(3'h5, 3'h7, 2'h2, 1'b0);
        for (i = 0; i < 40; i = i + 1)
            stk({$random(seed)} % 5 + 1, $random(seed), {$random(seed)} % 3, $random(seed));
        for (i = 0; i < 8; i = i + 1)
            dec(16'hF000 | $random(seed));
        close_out;
    end
endmodule
`default_nettype wire
